// *** hw/i2c_target_port.sv ***
`timescale 1ns/100ps
module i2c_target_port
   import i2c_port_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [1:0] addr_strap_high,
   input  wire logic [1:0] addr_strap_low,
   output logic      [7:0] rd_addr,
   input  wire logic [7:0] rd_data,
   output logic            wr_valid,
   output wr_word_t        wr_word,
   input  wire logic       wr_ready
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_prev;
   logic       sda_prev;
   logic [1:0] high_meta;
   logic [1:0] high_sync;
   logic [1:0] low_meta;
   logic [1:0] low_sync;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         high_meta <= 2'h0;
         high_sync <= 2'h0;
         low_meta  <= 2'h0;
         low_sync  <= 2'h0;
      end else begin
         high_meta <= addr_strap_high;
         high_sync <= high_meta;
         low_meta  <= addr_strap_low;
         low_sync  <= low_meta;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // line events from the second stage only, never from the first
   assign scl_rise   = scl_sync[1] && !scl_prev;
   assign scl_fall   = !scl_sync[1] && scl_prev;
   assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
   assign stop_seen  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   // straps are caught once after reset, so a pin that wanders later
   // cannot move the address under a live transfer
   logic [1:0] settle;
   logic       strap_done;
   logic [6:0] own_addr;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         settle     <= 2'h0;
         strap_done <= 1'b0;
         own_addr   <= 7'h00;
      end else if (!strap_done) begin
         if (settle == STRAP_SETTLE) begin
            strap_done <= 1'b1;
            own_addr   <= target_addr(high_sync, low_sync);
         end else begin
            settle <= settle + 2'h1;
         end
      end
   end

   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   port_state_t state;
   logic [3:0]  bit_cnt;
   logic [7:0]  shift;
   logic        rw;
   logic        acked;
   logic [7:0]  ptr;
   logic        push_valid;
   wr_word_t    push_word;
   logic        fifo_ready;
   logic        byte_end;
   logic        addr_hit;

   assign byte_end = scl_fall && (bit_cnt == BITS_BYTE);
   assign addr_hit = strap_done && (shift[7:1] == own_addr);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift   <= 8'h00;
         bit_cnt <= 4'h0;
      end else if (start_seen) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise) begin
         if (state == ST_ADDR || state == ST_OFFS || state == ST_WDATA) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (state == ST_RDATA) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end else if (scl_fall) begin
         if (state == ST_ADDR_ACK && rw) begin
            shift   <= rd_data;
            bit_cnt <= 4'h0;
         end else if (state == ST_RACK && acked) begin
            shift   <= rd_data;
            bit_cnt <= 4'h0;
         end else if (state == ST_RDATA && bit_cnt != BITS_BYTE) begin
            shift <= {shift[6:0], 1'b0};
         end else if (state == ST_ADDR_ACK || state == ST_OFFS_ACK || state == ST_WDAT_ACK) begin
            bit_cnt <= 4'h0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state  <= ST_IDLE;
         sda_oe <= 1'b0;
         rw     <= 1'b0;
         acked  <= 1'b0;
      end else if (stop_seen) begin
         state  <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_seen) begin
         state  <= ST_ADDR;
         sda_oe <= 1'b0;
      end else if (scl_rise && state == ST_RACK) begin
         acked <= !sda_sync[1];
      end else if (scl_fall) begin
         case (state)
            ST_ADDR: begin
               if (bit_cnt == BITS_BYTE) begin
                  if (addr_hit) begin
                     state  <= ST_ADDR_ACK;
                     sda_oe <= 1'b1;
                     rw     <= shift[0];
                  end else begin
                     state <= ST_WAIT_STOP;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (rw) begin
                  state  <= ST_RDATA;
                  sda_oe <= !rd_data[7];
               end else begin
                  state  <= ST_OFFS;
                  sda_oe <= 1'b0;
               end
            end
            ST_OFFS: begin
               if (bit_cnt == BITS_BYTE) begin
                  state  <= ST_OFFS_ACK;
                  sda_oe <= 1'b1;
               end
            end
            ST_OFFS_ACK, ST_WDAT_ACK: begin
               state  <= ST_WDATA;
               sda_oe <= 1'b0;
            end
            ST_WDATA: begin
               if (bit_cnt == BITS_BYTE) begin
                  // a full buffer refuses the byte rather than lose it
                  if (fifo_ready) begin
                     state  <= ST_WDAT_ACK;
                     sda_oe <= 1'b1;
                  end else begin
                     state <= ST_WAIT_STOP;
                  end
               end
            end
            ST_RDATA: begin
               if (bit_cnt == BITS_BYTE) begin
                  state  <= ST_RACK;
                  sda_oe <= 1'b0;
               end else begin
                  sda_oe <= !shift[6];
               end
            end
            ST_RACK: begin
               if (acked) begin
                  state  <= ST_RDATA;
                  sda_oe <= !rd_data[7];
               end else begin
                  state  <= ST_WAIT_STOP;
                  sda_oe <= 1'b0;
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // register pointer
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= PTR_RESET;
      end else if (byte_end && state == ST_OFFS) begin
         ptr <= shift;
      end else if (byte_end && state == ST_WDATA && fifo_ready) begin
         ptr <= ptr + 8'h01;
      end else if (byte_end && state == ST_RDATA) begin
         ptr <= ptr + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr <= PTR_RESET;
         sda_out <= 1'b0;
      end else begin
         rd_addr <= ptr;
         sda_out <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         push_valid <= 1'b0;
         push_word  <= '0;
      end else begin
         push_valid <= byte_end && state == ST_WDATA && fifo_ready;
         if (byte_end && state == ST_WDATA) begin
            push_word <= '{offset: ptr, data: shift};
         end
      end
   end

   // ----------------------------------------
   // write buffer
   // ----------------------------------------
   write_fifo #(
      .WIDTH ($bits(wr_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (push_valid),
      .in_ready  (fifo_ready),
      .in_data   (push_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence addr_end_s;
      state == ST_ADDR && byte_end && !start_seen && !stop_seen;
   endsequence

   sequence wdata_end_s;
      state == ST_WDATA && byte_end && fifo_ready && !start_seen && !stop_seen;
   endsequence

   addr_ack_a: assert property (addr_end_s ##0 addr_hit |=> sda_oe && state == ST_ADDR_ACK)
      else $error("matching address not acknowledged");
   addr_miss_a: assert property (addr_end_s ##0 !addr_hit |=> !sda_oe && state == ST_WAIT_STOP)
      else $error("foreign address acknowledged");
   restart_addr_a: assert property (start_seen && !stop_seen |=> state == ST_ADDR && !sda_oe)
      else $error("start did not open an address byte");
   dir_branch_a: assert property (state == ST_ADDR_ACK && scl_fall && !start_seen && !stop_seen
      |=> (rw ? state == ST_RDATA : state == ST_OFFS && !sda_oe))
      else $error("direction bit not followed");
   offset_load_a: assert property (state == ST_OFFS && byte_end && !stop_seen && !start_seen
      |=> ptr == $past(shift) && sda_oe)
      else $error("offset not loaded or not acknowledged");
   wr_push_a: assert property (wdata_end_s
      |=> push_valid && push_word.data == $past(shift) && push_word.offset == $past(ptr))
      else $error("written byte not queued");
   ptr_step_a: assert property (wdata_end_s |=> ptr == $past(ptr) + 8'h01 ##1 ptr == $past(ptr, 2) + 8'h01)
      else $error("write pointer did not advance by one");
   read_inc_a: assert property (state == ST_RDATA && byte_end && !stop_seen && !start_seen
      |=> ptr == $past(ptr) + 8'h01 && state == ST_RACK && !sda_oe)
      else $error("read pointer did not advance");
   first_bit_a: assert property (state == ST_ADDR_ACK && scl_fall && rw && !stop_seen && !start_seen
      |=> sda_oe == !$past(rd_data[7]))
      else $error("read byte msb not driven");
   nack_release_a: assert property (state == ST_RACK && scl_fall && !acked && !stop_seen && !start_seen
      |=> !sda_oe [*3])
      else $error("data line held after nack");
   stop_idle_a: assert property (stop_seen |=> state == ST_IDLE && !sda_oe && $stable(ptr))
      else $error("stop did not return to idle");

endmodule : i2c_target_port

// *** hw/i2c_port_pkg.sv ***
// Operation
// - strap levels select one of sixteen addresses
// - first byte: address, then direction bit
// - acknowledge a matching address, either direction
// - one offset byte loads the register pointer
// - store and acknowledge each written data byte while the buffer has room
// - offset-only write sets pointer, changes nothing
// - plain read starts at the current pointer
// - read bytes shift out MSB first
// - controller nack ends data until stop
// - offset write, repeated start, then read
// - pointer increments after every read byte
// - clock and open-drain data pins
package i2c_port_pkg;

   // ----------------------------------------
   // strap levels and address groups
   // ----------------------------------------
   localparam logic [1:0] STRAP_LOW   = 2'h0;
   localparam logic [1:0] STRAP_RES   = 2'h1;
   localparam logic [1:0] STRAP_FLOAT = 2'h2;
   localparam logic [1:0] STRAP_HIGH  = 2'h3;

   localparam logic [6:0] ADDR_GROUP_LOW   = 7'h44;
   localparam logic [6:0] ADDR_GROUP_RES   = 7'h20;
   localparam logic [6:0] ADDR_GROUP_FLOAT = 7'h10;
   localparam logic [6:0] ADDR_GROUP_HIGH  = 7'h0c;

   // ----------------------------------------
   // sizes and counts
   // ----------------------------------------
   localparam int         FIFO_DEPTH   = 8;
   localparam logic [3:0] BITS_BYTE    = 4'h8;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [7:0] PTR_RESET    = 8'h00;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] data;
   } wr_word_t;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_ADDR     = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_OFFS     = 9'h008,
      ST_OFFS_ACK = 9'h010,
      ST_WDATA    = 9'h020,
      ST_WDAT_ACK = 9'h040,
      ST_RDATA    = 9'h080,
      ST_RACK     = 9'h100
   } port_state_t;

   localparam port_state_t ST_WAIT_STOP = ST_IDLE;

   function automatic logic [6:0] target_addr(input logic [1:0] high, input logic [1:0] low);
      logic [6:0] base;
      case (high)
         STRAP_LOW:   base = ADDR_GROUP_LOW;
         STRAP_RES:   base = ADDR_GROUP_RES;
         STRAP_FLOAT: base = ADDR_GROUP_FLOAT;
         default:     base = ADDR_GROUP_HIGH;
      endcase
      return base + {5'h00, low};
   endfunction : target_addr

endpackage : i2c_port_pkg

// *** hw/write_fifo.sv ***
`timescale 1ns/100ps
module write_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // output stage is a register, refilled whenever it drains
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign pop      = (count != '0) && (!out_valid || out_ready);

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

endmodule : write_fifo

// *** sim/i2c_ctrl_model.sv ***
`timescale 1ns/100ps
module i2c_ctrl_model (
   output logic      scl,
   output logic      pull,
   input  wire logic sda
);
   logic [7:0] rd_last;
   logic       r;
   event       got;

   initial begin
      scl  = 1'b1;
      pull = 1'b0;
   end

   // -----------------------------
   // bit slot, 200 ns
   // -----------------------------
   // data moves 25 ns after the fall so no edge looks like start or stop
   task automatic bit_slot(input logic v, output logic s);
      #25 pull = ~v;
      #75 scl = 1'b1;
      #50 s = sda;
      #50 scl = 1'b0;
   endtask : bit_slot

   // low phase stretched: the target may still hold its ack after the fall
   task automatic start;
      #25 pull = 1'b0;
      #150 scl = 1'b1;
      #50 pull = 1'b1;
      #50 scl = 1'b0;
   endtask : start

   task automatic stop;
      #25 pull = 1'b1;
      #150 scl = 1'b1;
      #50 pull = 1'b0;
      #100;
   endtask : stop

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
      bit_slot(1'b1, r);
      ack = ~r;
   endtask : wr_byte

   task automatic rd_byte(input logic ack);
      for (int i = 7; i >= 0; i--) bit_slot(1'b1, rd_last[i]);
      ->got;
      bit_slot(~ack, r);
   endtask : rd_byte
endmodule : i2c_ctrl_model

// *** sim/i2c_target_port_test.sv ***
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module i2c_target_port_test
   import i2c_port_pkg::*;
;
   localparam logic [6:0] GROUP [4] = '{7'h44, 7'h20, 7'h10, 7'h0c};
   logic        clock, rst_n, wr_ready, stall, scl, pull, ack, sda_out, sda_oe, wr_valid;
   logic [1:0]  strap_hi, strap_lo;
   logic [7:0]  rd_addr, rd_data, ptr, e;
   logic [6:0]  dev;
   logic [15:0] w;
   logic [31:0] rnd;
   wr_word_t    wr_word;
   wire         sda_line;
   logic [7:0]  reg_file [256];
   logic [7:0]  exp_mem [256];
   logic [15:0] exp_wr [$];
   logic [7:0]  exp_rd [$];
   int          error_cnt, samples_checked;

   // open drain wire with pull-up
   assign sda_line = (sda_oe ? sda_out : 1'b1) & ~pull;
   assign rd_data  = reg_file[rd_addr];

   i2c_ctrl_model ctl (.scl(scl), .pull(pull), .sda(sda_line));
   i2c_target_port dut (.clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap_high(strap_hi), .addr_strap_low(strap_lo), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xorshift

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) begin
      rnd <= xorshift(rnd);
      wr_ready <= ~stall & rnd[0];
   end

   // -----------------------------
   // watchers
   // -----------------------------
   always @(posedge clock) if (wr_valid && wr_ready) begin
      reg_file[wr_word.offset] <= wr_word.data;
      w = exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx;
      `CHECK({wr_word.offset, wr_word.data}, w)
   end

   always @(ctl.got) begin
      e = exp_rd.size() ? exp_rd.pop_front() : 8'hxx;
      `CHECK(ctl.rd_last, e)
   end

   // -----------------------------
   // tasks
   // -----------------------------
   task automatic do_reset(input logic [3:0] s);
      @(posedge clock);
      rst_n <= 1'b0;
      strap_hi <= s[3:2];
      strap_lo <= s[1:0];
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (12) @(posedge clock);
      dev = GROUP[s[3:2]] + {5'h00, s[1:0]};
      ptr = 8'h00;
   endtask : do_reset

   task automatic send(input logic [7:0] b, input logic exp_ack);
      ctl.wr_byte(b, ack);
      `CHECK(ack, exp_ack)
   endtask : send

   task automatic do_write(input logic [7:0] off, input int n, input int n_ok);
      logic [7:0] d;
      ctl.start();
      send({dev, 1'b0}, 1'b1);
      send(off, 1'b1);
      ptr = off;
      for (int k = 0; k < n; k++) begin
         d = rnd[15:8];
         if (k < n_ok) begin
            exp_wr.push_back({ptr, d});
            exp_mem[ptr] = d;
            ptr++;
         end
         send(d, k < n_ok);
         if (k >= n_ok) break;
      end
      ctl.stop();
   endtask : do_write

   task automatic do_read(input logic use_off, input logic [7:0] off, input int n);
      if (use_off) begin
         ctl.start();
         send({dev, 1'b0}, 1'b1);
         send(off, 1'b1);
         ptr = off;
      end
      ctl.start();
      send({dev, 1'b1}, 1'b1);
      for (int k = 0; k < n; k++) begin
         exp_rd.push_back(exp_mem[ptr]);
         ptr++;
         ctl.rd_byte(k < n - 1);
      end
      repeat (8) @(posedge clock);
      `CHECK(sda_oe, 1'b0)
      ctl.stop();
   endtask : do_read

   task automatic drain;
      int k;
      k = 0;
      while (wr_valid !== 1'b0 && k < 200) begin
         @(posedge clock);
         k++;
      end
      `CHECK(wr_valid, 1'b0)
      @(posedge clock);
   endtask : drain

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   initial begin
      #1_000_000;
      error_cnt++;
      print_verdict();
   end

   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      rst_n = 1'b0;
      wr_ready = 1'b0;
      stall = 1'b0;
      strap_hi = 2'h0;
      strap_lo = 2'h0;
      rnd = 32'hfa8fa301;
      for (int i = 0; i < 256; i++) begin
         rnd = xorshift(rnd);
         reg_file[i] = rnd[7:0];
         exp_mem[i] = rnd[7:0];
      end
      for (int i = 0; i < 16; i++) begin
         do_reset(i[3:0]);
         if (i[0]) begin
            do_read(1'b0, 8'h00, 1);
         end else begin
            ctl.start();
            send({dev, 1'b0}, 1'b1);
            ctl.stop();
         end
         ctl.start();
         send({dev ^ 7'h01, 1'b0}, 1'b0);
         ctl.stop();
      end
      // offsets written stay inside the register map
      do_write(8'h20, 3, 3);
      drain();
      do_write(8'h0a, 0, 0);
      do_read(1'b0, 8'h00, 2);
      do_read(1'b0, 8'h00, 1);
      do_read(1'b1, 8'h20, 3);
      // buffer plus output stage hold nine words, the tenth is refused
      stall = 1'b1;
      for (int k = 0; k < 3; k++) do_write(8'h1c, 3, 3);
      do_write(8'h10, 1, 0);
      stall = 1'b0;
      drain();
      do_read(1'b1, 8'h1c, 3);
      `CHECK(exp_wr.size(), 0)
      print_verdict();
   end
endmodule : i2c_target_port_test
